// [rtl/pmcg_pkg.sv]
/*
  Package for the clock generator slice: register map, field layout,
  reset values and the carrier structs of the configuration.
  Assumes a 32-bit register port with byte addresses as printed.
*/
package pmcg_pkg;
  // Register byte addresses
  localparam logic [31:0] ADDR_MEASURE  = 32'hFFFFFC24;
  localparam logic [31:0] ADDR_PLL_A    = 32'hFFFFFC28;
  localparam logic [31:0] ADDR_PLL_B    = 32'hFFFFFC2C;
  localparam logic [31:0] ADDR_MASTER   = 32'hFFFFFC30;
  localparam logic [31:0] ADDR_STATUS   = 32'hFFFFFC68;
  localparam logic [31:0] ADDR_INT_STAT = 32'hFFFFFC70;
  localparam logic [31:0] ADDR_INT_MASK = 32'hFFFFFC74;
  // Field positions
  localparam int MEAS_VALID_BIT = 16;
  localparam int PLL_DIV_LSB    = 0;
  localparam int PLL_DLY_LSB    = 8;
  localparam int PLL_RNG_LSB    = 14;
  localparam int PLL_MUL_LSB    = 16;
  localparam int PLL_USB_LSB    = 28;
  localparam int PLL_ONE_BIT    = 29;
  localparam int MCK_CSS_LSB    = 0;
  localparam int MCK_CPU_CLOCK_DIVIDE_SEL_LSB   = 2;
  localparam int MCK_MASTER_DIVIDE_SEL_LSB   = 8;
  localparam int ST_LOCK_A_BIT  = 1;
  localparam int ST_LOCK_B_BIT  = 2;
  // Interrupt bits: lock A, lock B, measurement ready
  localparam int IRQ_LOCK_A     = 0;
  localparam int IRQ_LOCK_B     = 1;
  localparam int IRQ_MEAS       = 2;
  // Last slow count of the sixteen-period measurement window, reserved codes and the interrupt mask reset value
  localparam logic [3:0] MEAS_LAST_SLOW = 4'hF;
  localparam logic [2:0] CPU_CLOCK_DIVIDE_SEL_RESERVED  = 3'h7;
  localparam logic [1:0] DIV2_RESERVED  = 2'h3;
  localparam logic [2:0] IRQ_MASK_RESET = 3'h0;

  typedef struct packed {
    logic [1:0]  hi;   // Bits 29:28 as stored
    logic [10:0] mul;
    logic [1:0]  rng;
    logic [5:0]  dly;
    logic [7:0]  div;
  } pmcg_pll_cfg_s;

  typedef struct packed {
    logic [1:0] master_divide_sel;
    logic [2:0] cpu_clock_divide_sel;
    logic [1:0] master_source_select;
  } pmcg_mck_cfg_s;

  localparam pmcg_pll_cfg_s PLL_CFG_RESET = '0;
  localparam pmcg_mck_cfg_s MCK_CFG_RESET = '0;

  typedef enum logic [1:0] {
    MS_IDLE  = 2'b00,
    MS_COUNT = 2'b01,
    MS_DONE  = 2'b10
  } pmcg_meas_e;
endpackage

// [rtl/pmcg_clock_gen.sv]
/*
  Clock generator slice: main clock measurement, two PLL configurations
  with lock delay, USB divider, master clock selection and dividers.
  Assumes slow_clk_i and main_clk_i are sampled levels synchronous to
  clk_sys_i and toggle slower than half its rate.
*/
`timescale 1ns/1ps
`default_nettype none
module pmcg_clock_gen
  import pmcg_pkg::*;
(
  input  wire logic        clk_sys_i,
  input  wire logic        rstn_i,
  input  wire logic        ce_i,
  input  wire logic        slow_clk_i,
  input  wire logic        main_clk_i,
  input  wire logic        main_osc_en_i,
  input  wire logic [31:0] addr_i,
  input  wire logic [31:0] wdata_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  output logic      [31:0] rdata_o,
  output logic             irq_o,
  output logic             pll_a_ref_tick_o,
  output logic             pll_b_ref_tick_o,
  output logic             pll_a_on_o,
  output logic             pll_b_on_o,
  output logic      [11:0] pll_a_factor_o,
  output logic      [11:0] pll_b_factor_o,
  output logic      [1:0]  pll_a_range_o,
  output logic      [1:0]  pll_b_range_o,
  output logic             pll_a_lock_flag_o,
  output logic             pll_b_lock_flag_o,
  output logic      [2:0]  usb_ratio_o,
  output logic      [1:0]  master_source_select_o,
  output logic      [6:0]  cpu_ratio_o,
  output logic      [2:0]  master_ratio_o
);

  typedef struct packed {
    pmcg_pll_cfg_s cfg_a;
    pmcg_pll_cfg_s cfg_b;
    pmcg_mck_cfg_s mck;
    logic [5:0]    dly_a;
    logic [5:0]    dly_b;
    logic          lock_a;
    logic          lock_b;
    logic [7:0]    dcnt_a;
    logic [7:0]    dcnt_b;
    logic          tick_a;
    logic          tick_b;
    logic [11:0]   fac_a;
    logic [11:0]   fac_b;
    logic [2:0]    usb_ratio;
    logic [6:0]    cpu_ratio;
    logic [2:0]    mck_ratio;
    logic          slow_q;
    logic          main_q;
    pmcg_meas_e    meas_st;
    logic [3:0]    slow_cnt;
    logic [15:0]   main_cnt;
    logic [15:0]   meas;
    logic          meas_ok;
    logic [2:0]    int_st;
    logic [2:0]    int_mask;
    logic [31:0]   rdata;
  } pmcg_state_s;

  localparam pmcg_state_s ST_RESET = '{
    cfg_a: PLL_CFG_RESET, cfg_b: PLL_CFG_RESET, mck: MCK_CFG_RESET,
    meas_st: MS_IDLE, int_mask: IRQ_MASK_RESET, default: '0};

  pmcg_state_s st;
  pmcg_state_s nx;
  logic        rst_q1;
  logic        rst_n;
  logic        slow_rise;
  logic        main_rise;
  logic        wr_a;
  logic        wr_b;
  logic        wr_m;
  logic [2:0]  irq_set;

  // Divider step: code 0 never ticks, 1 ticks every edge, N every Nth
  function automatic logic [8:0] div_step(input logic [7:0] div,
                                          input logic [7:0] cnt,
                                          input logic       edge_in);
    logic [7:0] c;
    logic       t;
    c = cnt;
    t = 1'b0;
    if (edge_in && div != 8'h00) begin
      if (cnt >= div - 8'h01) begin
        c = 8'h00;
        t = 1'b1;
      end else begin
        c = cnt + 8'h01;
      end
    end
    return {t, c};
  endfunction

  // Two-bit ratio decode shared by the USB and master dividers
  function automatic logic [2:0] ratio2(input logic [1:0] code);
    return (code == DIV2_RESERVED) ? 3'h0 : 3'(3'h1 << code);
  endfunction

  // Reset release through two flip-flops
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rst_q1 <= 1'b0;
      rst_n  <= 1'b0;
    end else begin
      rst_q1 <= 1'b1;
      rst_n  <= rst_q1;
    end
  end

  assign slow_rise = slow_clk_i && !st.slow_q;
  assign main_rise = main_clk_i && !st.main_q;
  assign wr_a      = wr_i && addr_i == ADDR_PLL_A;
  assign wr_b      = wr_i && addr_i == ADDR_PLL_B;
  assign wr_m      = wr_i && addr_i == ADDR_MASTER;

  // Next-state logic for the whole block
  always_comb begin
    nx        = st;
    irq_set   = 3'h0;
    nx.slow_q = slow_clk_i;
    nx.main_q = main_clk_i;
    nx.rdata  = 32'h0;

    // Reference dividers on main clock edges
    {nx.tick_a, nx.dcnt_a} = div_step(st.cfg_a.div, st.dcnt_a, main_rise);
    {nx.tick_b, nx.dcnt_b} = div_step(st.cfg_b.div, st.dcnt_b, main_rise);

    // Lock delay counts down on slow clock edges
    if (slow_rise && !st.lock_a) begin
      nx.dly_a = st.dly_a - 6'h01;
      if (st.dly_a <= 6'h01) nx.lock_a = 1'b1;
    end
    if (slow_rise && !st.lock_b) begin
      nx.dly_b = st.dly_b - 6'h01;
      if (st.dly_b <= 6'h01) nx.lock_b = 1'b1;
    end

    // Configuration writes; a PLL write restarts that PLL's lock delay
    if (wr_a) begin
      nx.cfg_a.div = wdata_i[PLL_DIV_LSB +: 8];
      nx.cfg_a.dly = wdata_i[PLL_DLY_LSB +: 6];
      nx.cfg_a.rng = wdata_i[PLL_RNG_LSB +: 2];
      nx.cfg_a.mul = wdata_i[PLL_MUL_LSB +: 11];
      nx.cfg_a.hi  = {wdata_i[PLL_ONE_BIT], 1'b0};
      nx.fac_a     = {1'b0, wdata_i[PLL_MUL_LSB +: 11]} + 12'h001;
      nx.dly_a     = wdata_i[PLL_DLY_LSB +: 6];
      nx.lock_a    = wdata_i[PLL_DLY_LSB +: 6] == 6'h00;
      nx.dcnt_a    = 8'h00;
    end
    if (wr_b) begin
      nx.cfg_b.div = wdata_i[PLL_DIV_LSB +: 8];
      nx.cfg_b.dly = wdata_i[PLL_DLY_LSB +: 6];
      nx.cfg_b.rng = wdata_i[PLL_RNG_LSB +: 2];
      nx.cfg_b.mul = wdata_i[PLL_MUL_LSB +: 11];
      nx.cfg_b.hi  = wdata_i[PLL_USB_LSB +: 2];
      nx.fac_b     = {1'b0, wdata_i[PLL_MUL_LSB +: 11]} + 12'h001;
      nx.usb_ratio = ratio2(wdata_i[PLL_USB_LSB +: 2]);
      nx.dly_b     = wdata_i[PLL_DLY_LSB +: 6];
      nx.lock_b    = wdata_i[PLL_DLY_LSB +: 6] == 6'h00;
      nx.dcnt_b    = 8'h00;
    end
    if (wr_m) begin
      nx.mck.master_source_select  = wdata_i[MCK_CSS_LSB +: 2];
      nx.mck.cpu_clock_divide_sel = wdata_i[MCK_CPU_CLOCK_DIVIDE_SEL_LSB +: 3];
      nx.mck.master_divide_sel = wdata_i[MCK_MASTER_DIVIDE_SEL_LSB +: 2];
      nx.cpu_ratio = (wdata_i[MCK_CPU_CLOCK_DIVIDE_SEL_LSB +: 3] == CPU_CLOCK_DIVIDE_SEL_RESERVED) ? 7'h00
                   : 7'(7'h01 << wdata_i[MCK_CPU_CLOCK_DIVIDE_SEL_LSB +: 3]);
      nx.mck_ratio = ratio2(wdata_i[MCK_MASTER_DIVIDE_SEL_LSB +: 2]);
    end

    // Main clock measurement over the slow clock window
    unique case (st.meas_st)
      MS_IDLE: begin
        if (slow_rise) begin
          nx.meas_st  = MS_COUNT;
          nx.slow_cnt = 4'h0;
          nx.main_cnt = 16'h0000;
        end
      end
      MS_COUNT: begin
        if (main_rise) nx.main_cnt = st.main_cnt + 16'h0001;
        if (slow_rise) begin
          nx.slow_cnt = st.slow_cnt + 4'h1;
          if (st.slow_cnt == MEAS_LAST_SLOW) begin
            nx.meas    = nx.main_cnt;
            nx.meas_ok = 1'b1;
            nx.meas_st = MS_DONE;
            irq_set[IRQ_MEAS] = 1'b1;
          end
        end
      end
      MS_DONE: ;
      default: nx.meas_st = MS_IDLE;
    endcase
    if (!main_osc_en_i) begin
      nx.meas_st  = MS_IDLE;
      nx.meas_ok  = 1'b0;
      nx.slow_cnt = 4'h0;
      nx.main_cnt = 16'h0000;
    end

    // Sticky events; a set in the clearing cycle survives
    irq_set[IRQ_LOCK_A] = nx.lock_a && !st.lock_a;
    irq_set[IRQ_LOCK_B] = nx.lock_b && !st.lock_b;
    if (wr_i && addr_i == ADDR_INT_STAT) nx.int_st = st.int_st & ~wdata_i[2:0];
    if (wr_i && addr_i == ADDR_INT_MASK) nx.int_mask = wdata_i[2:0];
    nx.int_st = nx.int_st | irq_set;

    // Read data for the next cycle; unmapped addresses read zero
    if (rd_i) begin
      unique case (addr_i)
        ADDR_MEASURE:  nx.rdata = {15'h0, st.meas_ok, st.meas};
        ADDR_PLL_A:    nx.rdata = {2'b00, st.cfg_a.hi, 1'b0, st.cfg_a.mul,
                                   st.cfg_a.rng, st.cfg_a.dly, st.cfg_a.div};
        ADDR_PLL_B:    nx.rdata = {2'b00, st.cfg_b.hi, 1'b0, st.cfg_b.mul,
                                   st.cfg_b.rng, st.cfg_b.dly, st.cfg_b.div};
        ADDR_MASTER:   nx.rdata = {22'h0, st.mck.master_divide_sel, 3'h0, st.mck.cpu_clock_divide_sel, st.mck.master_source_select};
        ADDR_STATUS: begin
          nx.rdata[ST_LOCK_A_BIT] = st.lock_a;
          nx.rdata[ST_LOCK_B_BIT] = st.lock_b;
        end
        ADDR_INT_STAT: nx.rdata = {29'h0, st.int_st};
        ADDR_INT_MASK: nx.rdata = {29'h0, st.int_mask};
        default:       nx.rdata = 32'h0;
      endcase
    end
  end

  // State register, frozen while the clock enable is low
  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      st <= ST_RESET;
    end else if (ce_i) begin
      st <= nx;
    end
  end

  // Outputs
  assign rdata_o                = st.rdata;
  assign irq_o                  = |(st.int_st & st.int_mask);
  assign pll_a_ref_tick_o       = st.tick_a;
  assign pll_b_ref_tick_o       = st.tick_b;
  assign pll_a_on_o             = st.cfg_a.mul != 11'h000;
  assign pll_b_on_o             = st.cfg_b.mul != 11'h000;
  assign pll_a_factor_o         = st.fac_a;
  assign pll_b_factor_o         = st.fac_b;
  assign pll_a_range_o          = st.cfg_a.rng;
  assign pll_b_range_o          = st.cfg_b.rng;
  assign pll_a_lock_flag_o      = st.lock_a;
  assign pll_b_lock_flag_o      = st.lock_b;
  assign usb_ratio_o            = st.usb_ratio;
  assign master_source_select_o = st.mck.master_source_select;
  assign cpu_ratio_o            = st.cpu_ratio;
  assign master_ratio_o         = st.mck_ratio;

  // Checks, sampled only on enabled cycles
  default clocking cb @(posedge clk_sys_i iff ce_i); endclocking
  default disable iff (!rst_n);

  sequence s_div_a_off;
    st.cfg_a.div == 8'h00;
  endsequence
  sequence s_wr_a_delay;
    wr_a && wdata_i[PLL_DLY_LSB +: 6] != 6'h00;
  endsequence

  a_lock_a_restart: assert property (s_wr_a_delay |=> !st.lock_a)
    else $error("lock A not cleared by config write");
  a_lock_b_restart: assert property (
      wr_b && wdata_i[PLL_DLY_LSB +: 6] != 6'h00 |=> !st.lock_b)
    else $error("lock B not cleared by config write");
  a_lock_a_cause: assert property ($rose(st.lock_a) |-> $past(slow_rise || wr_a))
    else $error("lock A set without slow edge or write");
  a_meas_osc_off: assert property (!main_osc_en_i |=> !st.meas_ok)
    else $error("measurement valid with oscillator off");
  a_meas_window: assert property ($rose(st.meas_ok) |-> $past(st.slow_cnt) == 4'hF)
    else $error("measurement closed before sixteen slow periods");
  a_div_a_zero: assert property (s_div_a_off ##1 s_div_a_off |-> !st.tick_a)
    else $error("PLL A divider ticks while off");
  a_div_a_bypass: assert property (
      main_rise && st.cfg_a.div == 8'h01 && !wr_a |=> st.tick_a)
    else $error("PLL A bypass missed a main edge");
  a_lock_irq_path: assert property (
      $rose(st.lock_a) && st.int_mask[IRQ_LOCK_A] |-> irq_o)
    else $error("lock A event did not raise interrupt");
  a_cpu_ratio: assert property (
      wr_m && wdata_i[MCK_CPU_CLOCK_DIVIDE_SEL_LSB +: 3] == 3'h3 |=> cpu_ratio_o == 7'h08)
    else $error("prescaler code 3 not divide by 8");

endmodule // pmcg_clock_gen
`default_nettype wire

// [sim/test_pmcg_clock_gen.sv]
/*
  Self-checking bench for the clock generator slice: registers, decoded
  ratios, lock delay, reference ticks, interrupts and measurement.
  Assumes the design's package and a single 25 MHz system clock.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin error_cnt++; \
  $display("[FAIL] t=%0t got=%h exp=%h", $time, a, b); end end
module test_pmcg_clock_gen;
  import pmcg_pkg::*;
  logic clk_sys_i = 0, rstn_i = 0, ce_i = 1, slow_clk_i = 0, main_clk_i = 0;
  logic main_osc_en_i = 0, wr_i = 0, rd_i = 0;
  logic [31:0] addr_i = '0, wdata_i = '0, rdata_o, d, w, m;
  logic [11:0] fa, fb;
  logic [6:0]  cr;
  logic [2:0]  ur, mr;
  logic [1:0]  ra, rb, ms;
  logic irq_o, tka, tkb, ona, onb, lka, lkb, pv;
  int error_cnt = 0, checks_done = 0, e, t, n;
  logic [15:0] cyc = '0;
  int divs[5] = '{0, 1, 2, 3, 5};

  pmcg_clock_gen i_dut (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .ce_i(ce_i),
    .slow_clk_i(slow_clk_i), .main_clk_i(main_clk_i), .main_osc_en_i(main_osc_en_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .irq_o(irq_o), .pll_a_ref_tick_o(tka), .pll_b_ref_tick_o(tkb), .pll_a_on_o(ona),
    .pll_b_on_o(onb), .pll_a_factor_o(fa), .pll_b_factor_o(fb), .pll_a_range_o(ra),
    .pll_b_range_o(rb), .pll_a_lock_flag_o(lka), .pll_b_lock_flag_o(lkb),
    .usb_ratio_o(ur), .master_source_select_o(ms), .cpu_ratio_o(cr), .master_ratio_o(mr));

  // System clock; slow and main clocks as sampled levels, rising edges never coincide
  always #20 clk_sys_i = ~clk_sys_i;
  always @(posedge clk_sys_i) begin
    cyc        <= cyc + 16'h1;
    slow_clk_i <= cyc[5];
    main_clk_i <= cyc[1];
  end

  // Expected ratio of a two-bit divide code, zero for the reserved code
  function automatic logic [2:0] r3(input logic [1:0] c);
    return (c == 2'h3) ? 3'h0 : (3'h1 << c);
  endfunction

  task automatic wr_reg(input logic [31:0] a, input logic [31:0] v);
    @(posedge clk_sys_i);
    addr_i <= a; wdata_i <= v; wr_i <= 1'b1;
    @(posedge clk_sys_i);
    wr_i <= 1'b0;
  endtask

  task automatic rd_reg(input logic [31:0] a);
    @(posedge clk_sys_i);
    addr_i <= a; rd_i <= 1'b1;
    @(posedge clk_sys_i);
    rd_i <= 1'b0;
    #1 d = rdata_o;
  endtask

  // Write a PLL with lock delay k, count slow edges until its flag rises
  task automatic lock_test(input int p, input int k);
    wr_reg(p ? ADDR_PLL_B : ADDR_PLL_A, 32'h20010001 | (k << PLL_DLY_LSB));
    pv = slow_clk_i; e = 0;
    for (int i = 0; i < k * 64 + 200; i++) begin
      @(posedge clk_sys_i);
      if ((p ? lkb : lka) === 1'b1) break;
      if (slow_clk_i && !pv) e++;
      pv = slow_clk_i;
    end
    `CHK(e, k)
    rd_reg(ADDR_STATUS);
    `CHK(d[p ? ST_LOCK_B_BIT : ST_LOCK_A_BIT], 1'b1)
  endtask

  task automatic end_sim;
    $display("checks=%0d errors=%0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // Watchdog
  initial begin
    #(40 * 60000);
    error_cnt++;
    end_sim();
  end

  initial begin
    w = $urandom(32'h12682c10);
    repeat (5) @(posedge clk_sys_i);
    rstn_i <= 1'b1;
    repeat (3) @(posedge clk_sys_i);
    // Reset values, unmapped place, write with clock enable low
    rd_reg(ADDR_PLL_A); `CHK(d, 32'h0)
    rd_reg(ADDR_MASTER); `CHK(d, 32'h0)
    wr_reg(32'hFFFFFC38, 32'hFFFFFFFF); rd_reg(32'hFFFFFC38); `CHK(d, 32'h0)
    @(posedge clk_sys_i);
    ce_i <= 1'b0;
    wr_reg(ADDR_MASTER, 32'h1);
    ce_i <= 1'b1;
    rd_reg(ADDR_MASTER); `CHK(d, 32'h0)
    $display("test reset done");
    // Random configurations, every code of the range, USB, source and prescaler fields
    for (int i = 0; i < 8; i++) begin
      w = $urandom() & 32'h27FF00FF | 32'h20000000 | ((i % 4) << PLL_RNG_LSB);
      if (i == 0) w[26:16] = 11'h0;
      if (i == 1) w[26:16] = 11'h7FF;
      wr_reg(ADDR_PLL_A, w);
      wr_reg(ADDR_PLL_B, (w & 32'h07FFFFFF) | ((i % 4) << PLL_USB_LSB));
      m = $urandom() & 32'h300 | (i << MCK_CPU_CLOCK_DIVIDE_SEL_LSB) | (i % 4);
      wr_reg(ADDR_MASTER, m);
      rd_reg(ADDR_PLL_A); `CHK(d, w & 32'h27FFFFFF)
      rd_reg(ADDR_PLL_B); `CHK(d, (w & 32'h07FFFFFF) | ((i % 4) << PLL_USB_LSB))
      rd_reg(ADDR_MASTER); `CHK(d, m)
      `CHK(fa, {1'b0, w[26:16]} + 12'h1)
      `CHK(ona, w[26:16] != 11'h0)
      `CHK(fb, {1'b0, w[26:16]} + 12'h1)
      `CHK(onb, w[26:16] != 11'h0)
      `CHK(ra, w[15:14])
      `CHK(rb, w[15:14])
      `CHK(ur, r3(i[1:0]))
      `CHK(ms, i[1:0])
      `CHK(cr, (i == 7) ? 7'h0 : (7'h1 << i))
      `CHK(mr, r3(m[9:8]))
    end
    $display("test config done");
    // Reference dividers on both PLLs
    for (int p = 0; p < 2; p++) begin
      foreach (divs[j]) begin
        wr_reg(p ? ADDR_PLL_B : ADDR_PLL_A, 32'h20000000 | divs[j]);
        pv = main_clk_i; e = 0; t = 0;
        for (int k = 1; k <= 121; k++) begin
          @(posedge clk_sys_i);
          if (k <= 120 && main_clk_i && !pv) e++;
          if (k >= 2 && (p ? tkb : tka) === 1'b1) t++;
          pv = main_clk_i;
        end
        n = divs[j] ? e / divs[j] : 0;
        `CHK(t, n)
      end
    end
    $display("test divider done");
    // Lock delays, interrupt raised, masked and cleared
    wr_reg(ADDR_INT_STAT, 32'h7);
    wr_reg(ADDR_INT_MASK, 32'h1);
    rd_reg(ADDR_INT_MASK); `CHK(d, 32'h1)
    lock_test(0, 3);
    `CHK(irq_o, 1'b1)
    rd_reg(ADDR_INT_STAT); `CHK(d[IRQ_LOCK_A], 1'b1)
    wr_reg(ADDR_INT_STAT, 32'h1);
    rd_reg(ADDR_INT_STAT); `CHK(d[IRQ_LOCK_A], 1'b0)
    `CHK(irq_o, 1'b0)
    wr_reg(ADDR_INT_MASK, 32'h0);
    lock_test(1, 2);
    rd_reg(ADDR_INT_STAT); `CHK(d[IRQ_LOCK_B], 1'b1)
    `CHK(irq_o, 1'b0)
    lock_test(0, 0);
    lock_test(1, 0);
    for (int i = 0; i < 3; i++) lock_test(i % 2, 1 + $urandom_range(6));
    $display("test lock done");
    // Main clock measurement over sixteen slow periods
    rd_reg(ADDR_MEASURE); `CHK(d[MEAS_VALID_BIT], 1'b0)
    @(posedge clk_sys_i);
    main_osc_en_i <= 1'b1;
    repeat (200) @(posedge clk_sys_i);
    rd_reg(ADDR_MEASURE); `CHK(d[MEAS_VALID_BIT], 1'b0)
    repeat (1000) @(posedge clk_sys_i);
    rd_reg(ADDR_MEASURE);
    `CHK(d[MEAS_VALID_BIT], 1'b1)
    `CHK(d[15:0], 16'h0100)
    rd_reg(ADDR_INT_STAT);
    `CHK(d[IRQ_MEAS], 1'b1)
    @(posedge clk_sys_i);
    main_osc_en_i <= 1'b0;
    repeat (4) @(posedge clk_sys_i);
    rd_reg(ADDR_MEASURE); `CHK(d[MEAS_VALID_BIT], 1'b0)
    $display("test measure done");
    end_sim();
  end
endmodule // test_pmcg_clock_gen
`default_nettype wire
